// [ssc_core.sv]
// serial control core: shift port on the serial clock, register file and loop control on clk
// assumes a microcontroller master on serial_enable_n/serial_data/serial_clk; lock inputs are async
`timescale 1ns/1ps
`include "ssc_map.svh"
module ssc_core #(
  parameter int unsigned ADAPT_STEP_CYC = `SSC_ADAPT_STEP_CYC
) (
  // system
  input wire logic clk,
  input wire logic rst_n,
  // serial port
  input wire logic serial_clk,
  input wire logic serial_enable_n,
  input wire logic serial_data,
  // loop lock detectors
  input wire logic main_lock_raw,
  input wire logic sec_lock_raw,
  // lock and pumps
  output logic lock_indicator,
  output logic lock_window_select_bit,
  output logic high_current_pump_enable,
  output logic low_current_pump_enable,
  output logic secondary_detector_enable,
  output logic use_alternate_counters,
  // active divide ratios
  output logic [15:0] ref_ratio,
  output logic [17:0] main_ratio,
  output logic [15:0] sec_loop_ratio,
  output logic [15:0] sec_ref_ratio,
  // standby and general outputs
  output ssc_pkg::ssc_ctrl_s ctrl_byte,
  // multiplier
  output logic [1:0] refresh_rate_sel,
  output logic keep_alive_enable,
  // dacs
  output ssc_pkg::ssc_dac_s dac_codes,
  output logic [1:0] dac_low_power
);

  // serial clock domain
  logic [31:0] shift_q;
  logic [5:0] bits_q;
  logic link_clr;

  // shifting is gated by the enable, so an edge with enable high changes nothing
  always_ff @(posedge serial_clk) begin
    if (!serial_enable_n) begin
      shift_q <= {shift_q[30:0], serial_data};
    end
  end

  // the count is cleared by the clk side once the word has been taken, which also
  // resynchronises after an enable toggle with the serial clock low
  always_ff @(posedge serial_clk or posedge link_clr) begin
    if (link_clr) begin
      bits_q <= 6'h00;
    end else if (!serial_enable_n && bits_q != 6'h3f) begin
      bits_q <= bits_q + 6'h01;
    end
  end

  // synchronisers
  logic [2:0] enb_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] mlock_sync_q;
  logic [1:0] slock_sync_q;

  // serial port pins; enable resets high so no false rising edge follows reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      enb_sync_q <= 3'h7;
      sclk_sync_q <= 2'h0;
    end else begin
      enb_sync_q <= {enb_sync_q[1:0], serial_enable_n};
      sclk_sync_q <= {sclk_sync_q[0], serial_clk};
    end
  end

  // lock detector levels
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mlock_sync_q <= 2'h0;
      slock_sync_q <= 2'h0;
    end else begin
      mlock_sync_q <= {mlock_sync_q[0], main_lock_raw};
      slock_sync_q <= {slock_sync_q[0], sec_lock_raw};
    end
  end

  logic enb_rise;
  assign enb_rise = enb_sync_q[1] && !enb_sync_q[2];

  // clear request held while the port is idle; dropped as soon as enable goes low,
  // which precedes the first serial edge by far more than the synchroniser delay
  logic clr_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clr_q <= 1'b1;
    end else if (!enb_sync_q[1]) begin
      clr_q <= 1'b0;
    end else if (!enb_rise && !sclk_sync_q[1]) begin
      clr_q <= 1'b1;
    end
  end
  assign link_clr = clr_q;

  // word and count are quasi-static once enable is high, so they are read directly
  logic [31:0] word;
  logic [5:0] len;
  logic [3:0] adr;
  assign word = shift_q;
  assign len = bits_q;
  assign adr = word[`SSC_ADR_MSB:`SSC_ADR_LSB];

  function automatic logic hit(input logic [5:0] l, input logic [3:0] a, input logic [5:0] short_len,
                               input logic [3:0] want, input logic short_ok);
    hit = (short_ok && l == short_len) || (l == `SSC_LEN_ADDR && a == want);
  endfunction

  logic wr_ctrl, wr_href, wr_ndiv, wr_dac, wr_hsec, wr_rsec;
  assign wr_ctrl = enb_rise && hit(len, adr, `SSC_LEN_CTRL, `SSC_ADR_CTRL, 1'b1);
  assign wr_href = enb_rise && hit(len, adr, `SSC_LEN_HREF, `SSC_ADR_HREF, 1'b1);
  assign wr_ndiv = enb_rise && hit(len, adr, `SSC_LEN_NDIV, `SSC_ADR_NDIV, 1'b1);
  assign wr_dac = enb_rise && hit(len, adr, `SSC_LEN_ADDR, `SSC_ADR_DAC, 1'b0);
  assign wr_hsec = enb_rise && hit(len, adr, `SSC_LEN_ADDR, `SSC_ADR_HSEC, 1'b0);
  assign wr_rsec = enb_rise && hit(len, adr, `SSC_LEN_ADDR, `SSC_ADR_RSEC, 1'b0);

  // register file
  logic [7:0] ctrl_q;
  logic [15:0] href_q;
  logic [23:0] ndiv_q;
  logic [15:0] dac_q;
  logic [15:0] hsec_q;
  logic [23:0] rsec_q;
  logic [15:0] ref_act_q;
  logic [15:0] sec_act_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_q <= `SSC_RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_q <= word[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      href_q <= `SSC_RST_HREF;
    end else if (wr_href) begin
      href_q <= word[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ndiv_q <= `SSC_RST_NDIV;
    end else if (wr_ndiv) begin
      ndiv_q <= word[23:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_q <= `SSC_RST_DAC;
    end else if (wr_dac) begin
      dac_q <= word[15:0];
    end
  end

  // the unused low bits are stored as zero so the active copy never carries them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hsec_q <= `SSC_RST_HSEC;
    end else if (wr_hsec) begin
      hsec_q <= {word[15:`SSC_HSEC_UNUSED], 3'h0};
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rsec_q <= `SSC_RST_RSEC;
    end else if (wr_rsec) begin
      rsec_q <= word[23:0];
    end
  end

  // double buffer: holding contents become active only with a main divide write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_act_q <= `SSC_RST_HREF;
      sec_act_q <= `SSC_RST_HSEC;
    end else if (wr_ndiv) begin
      ref_act_q <= href_q;
      sec_act_q <= hsec_q;
    end
  end

  // adapt timer
  ssc_pkg::ssc_pump_e pump_mode;
  ssc_pkg::ssc_adapt_e adapt_q;
  logic [31:0] adapt_cnt_q;
  logic [31:0] adapt_len;
  assign pump_mode = ssc_pkg::ssc_pump_e'(ndiv_q[`SSC_N_PUMP_MSB:`SSC_N_PUMP_LSB]);
  assign adapt_len = (32'(ndiv_q[`SSC_N_PUMP_LSB+1:`SSC_N_PUMP_LSB]) + 32'h1) * 32'(ADAPT_STEP_CYC);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      adapt_q <= ssc_pkg::SSC_ADAPT_IDLE;
      adapt_cnt_q <= 32'h0;
    end else if (wr_ndiv) begin
      adapt_q <= word[`SSC_N_PUMP_MSB] ? ssc_pkg::SSC_ADAPT_RUN : ssc_pkg::SSC_ADAPT_IDLE;
      adapt_cnt_q <= 32'h0;
    end else begin
      case (adapt_q)
        ssc_pkg::SSC_ADAPT_RUN: begin
          if (adapt_cnt_q + 32'h1 >= adapt_len) begin
            adapt_q <= ssc_pkg::SSC_ADAPT_DONE;
          end else begin
            adapt_cnt_q <= adapt_cnt_q + 32'h1;
          end
        end
        ssc_pkg::SSC_ADAPT_IDLE: adapt_q <= ssc_pkg::SSC_ADAPT_IDLE;
        ssc_pkg::SSC_ADAPT_DONE: adapt_q <= ssc_pkg::SSC_ADAPT_DONE;
        default: adapt_q <= ssc_pkg::SSC_ADAPT_IDLE;
      endcase
    end
  end

  // pump drive
  ssc_pkg::ssc_ctrl_s ctrl;
  ssc_pkg::ssc_pump_drive_s drive;
  assign ctrl = ssc_pkg::ssc_ctrl_s'(ctrl_q);

  always_comb begin
    case (pump_mode)
      ssc_pkg::SSC_PUMP_FLOAT: drive.hi_lo = 2'h0;
      ssc_pkg::SSC_PUMP_LO: drive.hi_lo = 2'h1;
      ssc_pkg::SSC_PUMP_HI: drive.hi_lo = 2'h2;
      ssc_pkg::SSC_PUMP_BOTH: drive.hi_lo = 2'h3;
      default: drive.hi_lo = (adapt_q == ssc_pkg::SSC_ADAPT_DONE) ? 2'h1 : 2'h2;
    endcase
    if (ctrl.main_pump_float || ctrl.main_standby) begin
      drive.hi_lo = 2'h0;
    end
  end

  logic hi_q, lo_q, sdet_q, alt_q, win_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_q <= 1'b0;
      lo_q <= 1'b0;
    end else begin
      hi_q <= drive.hi_lo[1];
      lo_q <= drive.hi_lo[0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sdet_q <= 1'b0;
    end else begin
      sdet_q <= !ctrl.sec_det_float && !ctrl.sec_standby;
    end
  end

  // alternate set only once the adapt timer has run out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      alt_q <= 1'b0;
    end else begin
      alt_q <= ndiv_q[`SSC_N_ALT_BIT] && pump_mode[2] && adapt_q == ssc_pkg::SSC_ADAPT_DONE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      win_q <= 1'b0;
    end else begin
      win_q <= ndiv_q[`SSC_N_WIN_BIT];
    end
  end

  // combined lock indicator
  logic lock_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lock_q <= 1'b0;
    end else begin
      case ({ctrl.main_standby, ctrl.sec_standby})
        2'b00: lock_q <= mlock_sync_q[1] && slock_sync_q[1];
        2'b01: lock_q <= mlock_sync_q[1];
        2'b10: lock_q <= slock_sync_q[1];
        default: lock_q <= 1'b0;
      endcase
    end
  end

  // registered copies for the remaining outputs
  logic [1:0] refresh_q;
  logic keep_q;
  logic [1:0] dac_lp_q;
  logic [7:0] ctrl_out_q;
  logic [15:0] dac_out_q;
  logic [17:0] main_ratio_q;
  logic [15:0] sref_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      refresh_q <= 2'h0;
      keep_q <= 1'b0;
    end else begin
      refresh_q <= rsec_q[`SSC_RS_MULT_MSB:`SSC_RS_MULT_LSB];
      // zero refresh code is the inactive multiplier
      keep_q <= ctrl.ref_standby && (rsec_q[`SSC_RS_MULT_MSB:`SSC_RS_MULT_LSB] != 2'h0);
    end
  end

  // code and low-power flag come from the same register so they move together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dac_lp_q <= 2'h3;
      dac_out_q <= `SSC_RST_DAC;
    end else begin
      dac_lp_q <= {dac_q[15:8] == 8'h00, dac_q[7:0] == 8'h00};
      dac_out_q <= dac_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_out_q <= `SSC_RST_CTRL;
    end else begin
      ctrl_out_q <= ctrl_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      main_ratio_q <= 18'h00000;
      sref_q <= 16'h0000;
    end else begin
      main_ratio_q <= ndiv_q[`SSC_N_RATIO_MSB:0];
      sref_q <= rsec_q[`SSC_RS_RATIO_MSB:0];
    end
  end

  assign lock_indicator = lock_q;
  assign lock_window_select_bit = win_q;
  assign high_current_pump_enable = hi_q;
  assign low_current_pump_enable = lo_q;
  assign secondary_detector_enable = sdet_q;
  assign use_alternate_counters = alt_q;
  assign ref_ratio = ref_act_q;
  assign main_ratio = main_ratio_q;
  assign sec_loop_ratio = sec_act_q;
  assign sec_ref_ratio = sref_q;
  assign ctrl_byte = ssc_pkg::ssc_ctrl_s'(ctrl_out_q);
  assign refresh_rate_sel = refresh_q;
  assign keep_alive_enable = keep_q;
  assign dac_codes = ssc_pkg::ssc_dac_s'(dac_out_q);
  assign dac_low_power = dac_lp_q;

endmodule

// [ssc_core_monitor.sv]
// concurrent checks on the serial control core ports, clk domain only
// assumes ssc_pkg is compiled first; bound to every ssc_core
`timescale 1ns/1ps
module ssc_core_monitor #(
  parameter int unsigned ADAPT_STEP_CYC = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // watched ports
  input wire logic serial_enable_n,
  input wire logic main_lock_raw,
  input wire logic sec_lock_raw,
  input wire logic lock_indicator,
  input wire logic high_current_pump_enable,
  input wire logic low_current_pump_enable,
  input wire logic secondary_detector_enable,
  input wire logic [15:0] sec_loop_ratio,
  input wire ssc_pkg::ssc_ctrl_s ctrl_byte,
  input wire logic [1:0] refresh_rate_sel,
  input wire logic keep_alive_enable,
  input wire ssc_pkg::ssc_dac_s dac_codes,
  input wire logic [1:0] dac_low_power
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // six cycles covers the 3-4 cycle lock synchroniser latency
  sequence both_up_s;
    (!ctrl_byte.main_standby && !ctrl_byte.sec_standby && main_lock_raw && sec_lock_raw) [*6];
  endsequence
  sequence main_down_s;
    (!ctrl_byte.main_standby && !main_lock_raw) [*6];
  endsequence
  sequence quiet_s;
    serial_enable_n [*8];
  endsequence
  a_lock_both_up: assert property (both_up_s |-> lock_indicator)
    else $error("lock low with both loops locked");
  a_lock_main_down: assert property (main_down_s |-> !lock_indicator)
    else $error("lock high with main loop unlocked");
  a_lock_one_standby: assert property ((ctrl_byte.main_standby && !ctrl_byte.sec_standby && sec_lock_raw) [*6]
    |-> lock_indicator)
    else $error("lock ignores active loop");
  a_lock_all_standby: assert property ((ctrl_byte.main_standby && ctrl_byte.sec_standby) [*5] |-> !lock_indicator)
    else $error("lock high with both loops in standby");
  a_reset_state_out: assert property ($rose(rst_n) |-> !lock_indicator && dac_low_power == 2'h3)
    else $error("bad state after reset");
  a_pump_float_bit: assert property (ctrl_byte.main_pump_float [*3]
    |-> !high_current_pump_enable && !low_current_pump_enable)
    else $error("main pump driving while forced to float");
  a_sec_float_bit: assert property (ctrl_byte.sec_det_float [*3] |-> !secondary_detector_enable)
    else $error("secondary detector driving while forced to float");
  a_dac_power_mode: assert property ($stable(dac_codes) [*2]
    |-> dac_low_power == {dac_codes.code2 == 8'h00, dac_codes.code1 == 8'h00})
    else $error("dac low power does not match code");
  a_keep_alive_off: assert property ((refresh_rate_sel == 2'h0) [*3] |-> !keep_alive_enable)
    else $error("keep-alive on with multiplier inactive");
  a_sec_low_bits: assert property (sec_loop_ratio[2:0] == 3'h0)
    else $error("secondary ratio low bits not zero");
  a_idle_hold_regs: assert property (quiet_s |-> $stable(ctrl_byte) && $stable(dac_codes))
    else $error("register changed with no frame");
endmodule

bind ssc_core ssc_core_monitor #(.ADAPT_STEP_CYC(ADAPT_STEP_CYC)) u_monitor (
  .clk(clk), .rst_n(rst_n), .serial_enable_n(serial_enable_n), .main_lock_raw(main_lock_raw),
  .sec_lock_raw(sec_lock_raw), .lock_indicator(lock_indicator), .high_current_pump_enable(high_current_pump_enable),
  .low_current_pump_enable(low_current_pump_enable), .secondary_detector_enable(secondary_detector_enable),
  .sec_loop_ratio(sec_loop_ratio), .ctrl_byte(ctrl_byte), .refresh_rate_sel(refresh_rate_sel),
  .keep_alive_enable(keep_alive_enable), .dac_codes(dac_codes), .dac_low_power(dac_low_power)
);

// [ssc_map.svh]
// constants for the serial control core of a dual-loop synthesizer
// assumes inclusion by bare name from ssc_pkg.sv and ssc_core.sv
// Function
// - data arrives msb first, sampled on each rising serial clock edge
// - on enable rising, shifted word goes to register picked by length or address
// - unaddressed 8, 16, 24 bit bursts go to control, ref holding, main divide
// - every 32-bit burst is addressed; its address field picks the destination
// - dac, secondary holding and secondary reference only reachable by 32-bit access
// - main divide write also loads both holding registers into active ratios
// - serial logic resyncs whenever enable is high and serial clock is low
// - lock output is the and of both loop lock signals
// - one loop standby shows the other; both standby holds lock output low
// - loop lock high when locked; combined output shows unlocked after power-up
// - one main divide bit picks main lock window; secondary window fixed
// - main divide bits pick low only, high only, both, or both floating pumps
// - a control bit floats both main pumps whatever mode is selected
// - adapt mode runs high pump for timer interval, then low pump only
// - adapt mode may switch to alternate counter set after timer expiry
// - a control bit floats the secondary detector output
// - secondary reference bits set the multiplier refresh divider rate
// - inactive multiplier stops keep-alive oscillator during reference standby
// - dac register sets both 8-bit dac codes; zero scale means low power
// - reset leaves both dacs at zero scale, low power
// - with enable high the shift register ignores serial clock edges
// - holding registers are 16 bits; secondary holding low three bits unused
`ifndef SSC_MAP_SVH
`define SSC_MAP_SVH

`define SSC_LEN_CTRL 6'h08
`define SSC_LEN_HREF 6'h10
`define SSC_LEN_NDIV 6'h18
`define SSC_LEN_ADDR 6'h20

`define SSC_ADR_CTRL 4'h0
`define SSC_ADR_HREF 4'h1
`define SSC_ADR_NDIV 4'h2
`define SSC_ADR_DAC 4'h3
`define SSC_ADR_HSEC 4'h4
`define SSC_ADR_RSEC 4'h5

`define SSC_ADR_MSB 27
`define SSC_ADR_LSB 24

`define SSC_N_ALT_BIT 23
`define SSC_N_WIN_BIT 22
`define SSC_N_PUMP_MSB 21
`define SSC_N_PUMP_LSB 19
`define SSC_N_RATIO_MSB 17

`define SSC_RS_MULT_MSB 23
`define SSC_RS_MULT_LSB 22
`define SSC_RS_RATIO_MSB 15

`define SSC_HSEC_UNUSED 3

`define SSC_RST_CTRL 8'h02
`define SSC_RST_HREF 16'h0000
`define SSC_RST_NDIV 24'h000000
`define SSC_RST_DAC 16'h0000
`define SSC_RST_HSEC 16'h0000
`define SSC_RST_RSEC 24'h000000

`define SSC_CLK_NS 10
`define SSC_ADAPT_STEP_NS 10000
`define SSC_ADAPT_STEP_CYC ((`SSC_ADAPT_STEP_NS + `SSC_CLK_NS - 1) / `SSC_CLK_NS)

`endif

// [ssc_mcu.sv]
// microcontroller model driving the three-wire serial port
// assumes the core samples data on the rising serial clock edge
`timescale 1ns/1ps
module ssc_mcu (
  // serial port
  output logic serial_clk,
  output logic serial_enable_n,
  output logic serial_data
);
  initial begin
    serial_clk = 1'b0;
    serial_enable_n = 1'b1;
    serial_data = 1'b0;
  end
  // low n bits of w, msb first, 125 ns per bit; clock stands still between frames
  task automatic send(input int n, input logic [31:0] w);
    #123.7;
    serial_enable_n = 1'b0;
    #60;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data = w[i];
      #31.25 serial_clk = 1'b1;
      #62.5 serial_clk = 1'b0;
      #31.25;
    end
    #60;
    serial_enable_n = 1'b1;
    serial_data = ~serial_data; // released line must not look like held data
  endtask
endmodule

// [ssc_pkg.sv]
// types shared by the serial control core
// assumes ssc_map.svh sits in the same folder
`include "ssc_map.svh"
package ssc_pkg;

  typedef enum logic [2:0] {
    SSC_PUMP_FLOAT,
    SSC_PUMP_LO,
    SSC_PUMP_HI,
    SSC_PUMP_BOTH,
    SSC_PUMP_ADAPT0,
    SSC_PUMP_ADAPT1,
    SSC_PUMP_ADAPT2,
    SSC_PUMP_ADAPT3
  } ssc_pump_e;

  typedef enum logic [1:0] {
    SSC_ADAPT_IDLE,
    SSC_ADAPT_RUN,
    SSC_ADAPT_DONE
  } ssc_adapt_e;

  // control byte layout, msb first
  typedef struct packed {
    logic out_a_level;
    logic ext_ref;
    logic out_c_hiz;
    logic main_pump_float;
    logic sec_det_float;
    logic ref_standby;
    logic main_standby;
    logic sec_standby;
  } ssc_ctrl_s;

  typedef struct packed {
    logic [1:0] hi_lo;
  } ssc_pump_drive_s;

  typedef struct packed {
    logic [7:0] code2;
    logic [7:0] code1;
  } ssc_dac_s;

endpackage

// [synth_serial_control_bench.sv]
// self-checking bench for the serial control core
// assumes ssc_mcu drives the serial port; lock inputs are driven on clk
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fails++; \
  $display("Error t=%0t got %h exp %h", $time, got, exp); end end
module synth_serial_control_bench;
  logic clk, rst_n, main_lock_raw, sec_lock_raw, serial_clk, serial_enable_n, serial_data;
  logic lock_indicator, lock_window_select_bit, hi_pump, lo_pump, sec_det, use_alt, keep;
  logic [15:0] ref_ratio, sec_loop_ratio, sec_ref_ratio;
  logic [17:0] main_ratio;
  logic [1:0] refresh_rate_sel, dac_low_power;
  ssc_pkg::ssc_ctrl_s ctrl_byte;
  ssc_pkg::ssc_dac_s dac_codes;
  int fails = 0;
  int compares = 0;
  // ctrl byte, main lock, sec lock, expected lock output
  localparam logic [10:0] LT [5] = '{{8'h00, 3'b111}, {8'h00, 3'b010}, {8'h02, 3'b011}, {8'h01, 3'b101},
    {8'h03, 3'b110}};
  ssc_core #(.ADAPT_STEP_CYC(4)) DUT (
    .clk(clk), .rst_n(rst_n), .serial_clk(serial_clk), .serial_enable_n(serial_enable_n),
    .serial_data(serial_data), .main_lock_raw(main_lock_raw), .sec_lock_raw(sec_lock_raw),
    .lock_indicator(lock_indicator), .lock_window_select_bit(lock_window_select_bit),
    .high_current_pump_enable(hi_pump), .low_current_pump_enable(lo_pump), .secondary_detector_enable(sec_det),
    .use_alternate_counters(use_alt), .ref_ratio(ref_ratio), .main_ratio(main_ratio),
    .sec_loop_ratio(sec_loop_ratio), .sec_ref_ratio(sec_ref_ratio), .ctrl_byte(ctrl_byte),
    .refresh_rate_sel(refresh_rate_sel), .keep_alive_enable(keep), .dac_codes(dac_codes),
    .dac_low_power(dac_low_power)
  );
  ssc_mcu mcu (.serial_clk(serial_clk), .serial_enable_n(serial_enable_n), .serial_data(serial_data));
  task automatic put(input int n, input logic [31:0] w, input int settle);
    mcu.send(n, w);
    repeat (settle) @(posedge clk);
  endtask
  task automatic stop_test();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #500000;
    fails++;
    stop_test();
  end
  initial begin
    rst_n = 1'b0;
    main_lock_raw = 1'b0;
    sec_lock_raw = 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    `CHK(lock_indicator, 1'b0)
    `CHK(dac_low_power, 2'h3)
    `CHK(dac_codes, 16'h0000)
    put(8, 32'h00, 8);
    `CHK(ctrl_byte, 8'h00)
    put(16, 32'h1234, 8);
    put(32, 32'h0400abcf, 8);
    `CHK(ref_ratio, 16'h0000)
    `CHK(sec_loop_ratio, 16'h0000)
    for (int m = 0; m < 4; m++) begin
      put(24, 32'h400abc | (m << 19), 8);
      `CHK({hi_pump, lo_pump}, m[1:0])
    end
    `CHK(main_ratio, 18'h00abc)
    `CHK(ref_ratio, 16'h1234)
    `CHK(sec_loop_ratio, 16'habc8)
    `CHK(lock_window_select_bit, 1'b1)
    `CHK(sec_det, 1'b1)
    put(8, 32'h18, 8);
    `CHK({hi_pump, lo_pump}, 2'h0)
    `CHK(sec_det, 1'b0)
    put(8, 32'h00, 1);
    put(24, 32'hb80000, 6);
    `CHK({hi_pump, lo_pump}, 2'h2)
    `CHK(use_alt, 1'b0)
    repeat (30) @(posedge clk);
    `CHK({hi_pump, lo_pump}, 2'h1)
    `CHK(use_alt, 1'b1)
    `CHK(lock_window_select_bit, 1'b0)
    put(32, 32'h03005a00, 8);
    `CHK(dac_codes, 16'h5a00)
    `CHK(dac_low_power, 2'h1)
    put(16, 32'h0000, 8);
    `CHK(dac_codes, 16'h5a00)
    put(12, 32'h0ff, 8);
    `CHK(ctrl_byte, 8'h00)
    put(32, 32'h09000055, 8);
    `CHK(ctrl_byte, 8'h00)
    put(32, 32'h00000004, 8);
    `CHK(ctrl_byte, 8'h04)
    put(32, 32'h05c00123, 8);
    `CHK(refresh_rate_sel, 2'h3)
    `CHK(sec_ref_ratio, 16'h0123)
    `CHK(keep, 1'b1)
    put(32, 32'h05000123, 8);
    `CHK(keep, 1'b0)
    for (int k = 0; k < 5; k++) begin
      put(8, {24'h0, LT[k][10:3]}, 1);
      {main_lock_raw, sec_lock_raw} <= LT[k][2:1];
      repeat (10) @(posedge clk);
      `CHK(lock_indicator, LT[k][0])
    end
    stop_test();
  end
endmodule
